// *** verilog/tssu_pkg.sv ***
package tssu_pkg;

  localparam int XLEN = 64;
  localparam int IMM_W = 16;

  // instruction word fields
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int SUB_HI = 20;
  localparam int SUB_LO = 16;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int IMM_HI = 15;
  localparam int IMM_SIGN = 15;
  localparam int SEL_HI = 2;
  localparam int GRP_HI = 5;
  localparam int GRP_LO = 3;

  // primary opcodes
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_IMM_CLASS = 6'h01;

  // function codes of the register-type group
  localparam logic [5:0] FN_SYSCALL = 6'h0C;
  localparam logic [5:0] FN_BREAK = 6'h0D;
  localparam logic [5:0] FN_SYNC = 6'h0F;
  localparam logic [2:0] FN_TRAP_GRP = 3'h6;

  // sub codes of the register-immediate class
  localparam logic [1:0] RI_TRAP_GRP = 2'h1;

  // compare selector, low three bits of funct or sub
  localparam logic [2:0] SEL_GE = 3'h0;
  localparam logic [2:0] SEL_GEU = 3'h1;
  localparam logic [2:0] SEL_LT = 3'h2;
  localparam logic [2:0] SEL_LTU = 3'h3;
  localparam logic [2:0] SEL_EQ = 3'h4;
  localparam logic [2:0] SEL_NE = 3'h6;

  typedef enum logic [1:0] {
    CAUSE_NONE    = 2'h0,
    CAUSE_SYSCALL = 2'h1,
    CAUSE_BREAK   = 2'h2,
    CAUSE_TRAP    = 2'h3
  } tssu_cause_e;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'h0,
    ST_SYNC_WAIT = 2'h1,
    ST_EXC_HOLD  = 2'h3
  } tssu_state_e;

  typedef struct packed {
    logic [31:0]     instr;
    logic [XLEN-1:0] pc;
    logic [XLEN-1:0] first_operand_reg;
    logic [XLEN-1:0] second_operand_reg;
    logic            is_mem;
  } tssu_req_s;

  typedef struct packed {
    tssu_cause_e     cause;
    logic [XLEN-1:0] epc;
  } tssu_exc_s;

endpackage

// *** verilog/tssu_unit.sv ***
`timescale 1ns/10ps
// How it works
// RL1 - barrier holds later memory ops until drained; an exception raised in the wait ends it, so ops resume at ack
// RL2 - system-call always raises its exception
// RL3 - debug-stop always raises breakpoint exception
// RL4 - both decoded from register-type function field
// RL5 - traps only with extended ISA enabled
// RL6 - register trap on signed greater-or-equal
// RL7 - register trap on unsigned greater-or-equal
// RL8 - register trap on signed less-than
// RL9 - register trap on unsigned less-than
// RL10 - register trap when operands equal
// RL11 - register trap when operands differ
// RL12 - signed immediate traps use sign-extended immediate
// RL13 - unsigned immediate traps compare unsigned
// RL14 - immediate trap on equal
// RL15 - immediate trap on not equal
// RL16 - false trap retires quietly, no register write
// RL17 - exception precise, younger work held off
module tssu_unit #(
  parameter bit EXT_ISA = 1'b1
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rstn_i,
  input  wire logic               req_valid_i,
  input  wire tssu_pkg::tssu_req_s req_i,
  output logic                    req_ready_o,
  input  wire logic               lsu_pending_i,
  output logic                    mem_hold_o,
  output logic                    exc_valid_o,
  output tssu_pkg::tssu_exc_s     exc_o,
  output logic                    flush_younger_o,
  input  wire logic               exc_ack_i,
  output logic                    retire_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [tssu_pkg::XLEN-1:0] ext_imm(
    input logic [tssu_pkg::IMM_HI:0] imm
  );
    ext_imm = {{(tssu_pkg::XLEN-tssu_pkg::IMM_W){imm[tssu_pkg::IMM_SIGN]}}, imm};
  endfunction

  function automatic logic cmp_hit(
    input logic [2:0]                sel,
    input logic [tssu_pkg::XLEN-1:0] a,
    input logic [tssu_pkg::XLEN-1:0] b
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      tssu_pkg::SEL_GE:  hit = ($signed(a) >= $signed(b));
      tssu_pkg::SEL_GEU: hit = (a >= b);
      tssu_pkg::SEL_LT:  hit = ($signed(a) < $signed(b));
      tssu_pkg::SEL_LTU: hit = (a < b);
      tssu_pkg::SEL_EQ:  hit = (a == b);
      tssu_pkg::SEL_NE:  hit = (a != b);
      default:           hit = 1'b0;
    endcase
    cmp_hit = hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  tssu_pkg::tssu_state_e state_q;
  tssu_pkg::tssu_state_e state_d;
  logic                  exc_valid_q;
  tssu_pkg::tssu_exc_s   exc_q;
  tssu_pkg::tssu_exc_s   exc_d;
  logic                  retire_q;

  wire [5:0] op_w = req_i.instr[tssu_pkg::OP_HI:tssu_pkg::OP_LO];
  wire [5:0] fn_w = req_i.instr[tssu_pkg::FN_HI:tssu_pkg::FN_LO];
  wire [4:0] sub_w = req_i.instr[tssu_pkg::SUB_HI:tssu_pkg::SUB_LO];
  wire [tssu_pkg::IMM_HI:0] imm_w = req_i.instr[tssu_pkg::IMM_HI:0];

  wire is_special_w = (op_w == tssu_pkg::OP_SPECIAL);
  wire is_imm_class_w = (op_w == tssu_pkg::OP_IMM_CLASS);

  wire is_syscall_w = is_special_w && (fn_w == tssu_pkg::FN_SYSCALL); // see RL4
  wire is_break_w = is_special_w && (fn_w == tssu_pkg::FN_BREAK); // see RL4
  wire is_sync_w = is_special_w && (fn_w == tssu_pkg::FN_SYNC);

  // selector codes 5 and 7 are holes in both trap groups
  wire sel_ok_reg_w = (fn_w[tssu_pkg::SEL_HI:0] != 3'h5) && (fn_w[tssu_pkg::SEL_HI:0] != 3'h7);
  wire sel_ok_imm_w = (sub_w[tssu_pkg::SEL_HI:0] != 3'h5) && (sub_w[tssu_pkg::SEL_HI:0] != 3'h7);

  wire trap_reg_w = EXT_ISA && is_special_w && sel_ok_reg_w
                  && (fn_w[tssu_pkg::GRP_HI:tssu_pkg::GRP_LO] == tssu_pkg::FN_TRAP_GRP); // see RL5
  wire trap_imm_w = EXT_ISA && is_imm_class_w && sel_ok_imm_w
                  && (sub_w[4:3] == tssu_pkg::RI_TRAP_GRP); // see RL5
  wire is_trap_w = trap_reg_w || trap_imm_w;

  wire [2:0] sel_w = trap_reg_w ? fn_w[tssu_pkg::SEL_HI:0] : sub_w[tssu_pkg::SEL_HI:0];

  // unsigned immediate forms still sign-extend, then compare unsigned
  wire [tssu_pkg::XLEN-1:0] imm_x_w = ext_imm(imm_w); // see RL12 see RL13
  wire [tssu_pkg::XLEN-1:0] opb_w = trap_reg_w ? req_i.second_operand_reg : imm_x_w;

  // see RL6 see RL7 see RL8 see RL9 see RL10 see RL11 see RL14 see RL15
  wire trap_hit_w = is_trap_w && cmp_hit(sel_w, req_i.first_operand_reg, opb_w);

  ////////////////////////////////////////////////////////////////////////////
  // handshake

  // during the barrier only memory ops wait; alu work flows on
  wire sync_block_w = (state_q == tssu_pkg::ST_SYNC_WAIT) && req_i.is_mem; // see RL1
  wire hold_w = (state_q == tssu_pkg::ST_EXC_HOLD); // see RL17

  assign req_ready_o = !hold_w && !sync_block_w;

  wire acc_w = req_valid_i && req_ready_o;
  wire raise_w = acc_w && (is_syscall_w || is_break_w || trap_hit_w); // see RL2 see RL3
  wire quiet_w = acc_w && (is_sync_w || (is_trap_w && !trap_hit_w)); // see RL16

  assign mem_hold_o = (state_q == tssu_pkg::ST_SYNC_WAIT)
                    || (acc_w && is_sync_w && lsu_pending_i); // see RL1

  assign flush_younger_o = hold_w; // see RL17

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tssu_pkg::ST_IDLE: begin
        if (raise_w) begin
          state_d = tssu_pkg::ST_EXC_HOLD;
        end else if (acc_w && is_sync_w && lsu_pending_i) begin
          state_d = tssu_pkg::ST_SYNC_WAIT;
        end
      end
      tssu_pkg::ST_SYNC_WAIT: begin
        if (raise_w) begin
          state_d = tssu_pkg::ST_EXC_HOLD;
        end else if (!lsu_pending_i) begin
          state_d = tssu_pkg::ST_IDLE;
        end
      end
      tssu_pkg::ST_EXC_HOLD: begin
        if (exc_ack_i) begin
          state_d = tssu_pkg::ST_IDLE;
        end
      end
      default: state_d = tssu_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    exc_d.epc = req_i.pc;
    if (is_syscall_w) begin
      exc_d.cause = tssu_pkg::CAUSE_SYSCALL;
    end else if (is_break_w) begin
      exc_d.cause = tssu_pkg::CAUSE_BREAK;
    end else begin
      exc_d.cause = tssu_pkg::CAUSE_TRAP;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_q <= tssu_pkg::ST_IDLE;
      exc_valid_q <= 1'b0;
      retire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      exc_valid_q <= raise_w;
      retire_q <= quiet_w;
    end
  end

  // cause and epc keep the last reported exception until the next one
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      exc_q <= '{cause: tssu_pkg::CAUSE_NONE, epc: '0};
    end else if (raise_w) begin
      exc_q <= exc_d;
    end
  end

  assign exc_valid_o = exc_valid_q;
  assign exc_o = exc_q;
  assign retire_o = retire_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // reference immediate built apart from the datapath helper, so a slip there shows up
  wire [tssu_pkg::XLEN-1:0] chk_imm_w = {{(tssu_pkg::XLEN-tssu_pkg::IMM_W){req_i.instr[tssu_pkg::IMM_SIGN]}},
                                         req_i.instr[tssu_pkg::IMM_HI:0]};

  a_sync_blocks_mem: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL1
    (state_q == tssu_pkg::ST_SYNC_WAIT) && req_i.is_mem |-> !req_ready_o && mem_hold_o)
    else $error("memory op accepted during barrier");

  a_sync_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL1
    (state_q == tssu_pkg::ST_SYNC_WAIT) && !lsu_pending_i && !raise_w
    |=> state_q == tssu_pkg::ST_IDLE)
    else $error("barrier not released after drain");

  a_syscall_raise: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL2
    acc_w && is_syscall_w |=> exc_valid_o && (exc_o.cause == tssu_pkg::CAUSE_SYSCALL)
    && (exc_o.epc == $past(req_i.pc)))
    else $error("system call exception missing");

  a_break_raise: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL3
    acc_w && is_break_w |=> exc_valid_o && (exc_o.cause == tssu_pkg::CAUSE_BREAK))
    else $error("breakpoint exception missing");

  a_base_no_trap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL5
    !EXT_ISA && acc_w && !is_syscall_w && !is_break_w |=> !exc_valid_o)
    else $error("trap raised in base variant");

  a_ge_signed_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL6
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_GE)
    |=> exc_valid_o == ($signed($past(req_i.first_operand_reg)) >= $signed($past(req_i.second_operand_reg))))
    else $error("signed register compare wrong");

  a_lt_unsigned_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL13
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_LTU)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) < $past(chk_imm_w)))
    else $error("unsigned immediate compare wrong");

  a_quiet_retire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL16
    acc_w && is_trap_w && !trap_hit_w |=> retire_o && !exc_valid_o)
    else $error("false trap did not retire quietly");

  a_exc_precise: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL17
    exc_valid_o |-> flush_younger_o && !req_ready_o && !retire_o)
    else $error("younger work not held on exception");

  a_hold_until_ack: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL17
    hold_w && !exc_ack_i |=> hold_w)
    else $error("hold dropped before acknowledge");

  // every trap form is judged one cycle on, at the exception pulse itself
  a_ge_unsigned_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL7
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_GEU)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) >= $past(req_i.second_operand_reg)))
    else $error("unsigned register ge compare wrong");

  a_lt_signed_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL8
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_LT)
    |=> exc_valid_o == ($signed($past(req_i.first_operand_reg)) < $signed($past(req_i.second_operand_reg))))
    else $error("signed register lt compare wrong");

  a_lt_unsigned_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL9
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_LTU)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) < $past(req_i.second_operand_reg)))
    else $error("unsigned register lt compare wrong");

  a_equal_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL10
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_EQ)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) == $past(req_i.second_operand_reg)))
    else $error("register equal compare wrong");

  a_notequal_reg: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL11
    acc_w && trap_reg_w && (sel_w == tssu_pkg::SEL_NE)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) != $past(req_i.second_operand_reg)))
    else $error("register not equal compare wrong");

  a_ge_signed_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL12
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_GE)
    |=> exc_valid_o == ($signed($past(req_i.first_operand_reg)) >= $signed($past(chk_imm_w))))
    else $error("signed immediate ge compare wrong");

  a_lt_signed_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL12
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_LT)
    |=> exc_valid_o == ($signed($past(req_i.first_operand_reg)) < $signed($past(chk_imm_w))))
    else $error("signed immediate lt compare wrong");

  a_ge_unsigned_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL13
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_GEU)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) >= $past(chk_imm_w)))
    else $error("unsigned immediate ge compare wrong");

  a_equal_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL14
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_EQ)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) == $past(chk_imm_w)))
    else $error("immediate equal compare wrong");

  a_notequal_imm: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL15
    acc_w && trap_imm_w && (sel_w == tssu_pkg::SEL_NE)
    |=> exc_valid_o == ($past(req_i.first_operand_reg) != $past(chk_imm_w)))
    else $error("immediate not equal compare wrong");

  a_sync_hold_set: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL1
    acc_w && is_sync_w && lsu_pending_i
    |-> mem_hold_o ##1 mem_hold_o)
    else $error("barrier hold not raised");

  a_sync_retire: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL16
    acc_w && is_sync_w |=> retire_o && !exc_valid_o)
    else $error("barrier did not retire");

  a_exc_one_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL17
    exc_valid_o |=> !exc_valid_o)
    else $error("exception pulse longer than one cycle");

  a_ack_release: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // see RL17
    hold_w && exc_ack_i
    |=> !flush_younger_o && req_ready_o)
    else $error("acknowledge did not release the hold");

endmodule

// *** test/tssu_far_end.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far side: exception unit takes control after a set wait,
// load/store unit stays busy a set count after each started memory op
module tssu_far_end (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       flush_i,
  input  wire logic       mem_start_i,
  input  wire logic [3:0] ack_wait_i,
  input  wire logic [3:0] pend_len_i,
  output logic            exc_ack_o,
  output logic            lsu_pending_o
);
  logic [3:0] ack_cnt_q;
  logic [3:0] pend_cnt_q;
  assign lsu_pending_o = pend_cnt_q != 4'h0;
  // ack is a one-cycle pulse; it clears itself the cycle after it rises so no stale ack meets the next exception
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ack_cnt_q  <= 4'h0;
      exc_ack_o  <= 1'b0;
      pend_cnt_q <= 4'h0;
    end else begin
      ack_cnt_q  <= (flush_i && !exc_ack_o) ? ack_cnt_q + 4'h1 : 4'h0;
      exc_ack_o  <= flush_i && !exc_ack_o && ack_cnt_q >= ack_wait_i;
      pend_cnt_q <= mem_start_i ? pend_len_i : pend_cnt_q - 4'(lsu_pending_o);
    end
  end
endmodule

// *** test/trap_syscall_sync_unit_tb_top.sv ***
`timescale 1ns/10ps
module trap_syscall_sync_unit_tb_top;
  logic                clk, rstn, vld, rdy, hold, exc, flush, ack, ret, pend, mst, b_exc, b_ret;
  tssu_pkg::tssu_req_s req;
  tssu_pkg::tssu_exc_s eo, b_eo;
  logic [3:0]          aw;
  logic [31:0]         seed = 32'hD28BF88E;
  int                  n_errors, checks, cyc;
  tssu_unit u_dut (.sys_clk_i(clk), .rstn_i(rstn), .req_valid_i(vld), .req_i(req), .req_ready_o(rdy),
    .lsu_pending_i(pend), .mem_hold_o(hold), .exc_valid_o(exc), .exc_o(eo), .flush_younger_o(flush),
    .exc_ack_i(ack), .retire_o(ret));
  // base variant sees the same stream; it must ignore every trap encoding
  tssu_unit #(.EXT_ISA(1'b0)) u_base (.sys_clk_i(clk), .rstn_i(rstn), .req_valid_i(vld), .req_i(req),
    .req_ready_o(), .lsu_pending_i(pend), .mem_hold_o(), .exc_valid_o(b_exc), .exc_o(b_eo),
    .flush_younger_o(), .exc_ack_i(ack), .retire_o(b_ret));
  tssu_far_end u_far (.sys_clk_i(clk), .rstn_i(rstn), .flush_i(flush), .mem_start_i(mst),
    .ack_wait_i(aw), .pend_len_i(4'h6), .exc_ack_o(ack), .lsu_pending_o(pend));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // {retire, cause}; the unsigned immediate forms still sign-extend
  function automatic logic [2:0] want(logic [31:0] i, logic [63:0] a, logic [63:0] b, bit ext);
    logic [63:0] y;
    logic [2:0]  s;
    logic        t;
    y = i[26] ? {{48{i[15]}}, i[15:0]} : b;
    s = i[26] ? i[18:16] : i[2:0];
    t = s == 3'h0 ? $signed(a) >= $signed(y) : s == 3'h1 ? a >= y : s == 3'h2 ? $signed(a) < $signed(y)
      : s == 3'h3 ? a < y : s == 3'h4 ? a == y : a != y;
    if (i[31:26] == 6'h00 && i[5:0] == 6'h0C) return 3'h1;
    if (i[31:26] == 6'h00 && i[5:0] == 6'h0D) return 3'h2;
    if (i[31:26] == 6'h00 && i[5:0] == 6'h0F) return 3'h4;
    // selectors 5 and 7 are unused codes in both trap groups: taken, no answer
    if (s[2] && s[0]) return 3'h0;
    if (ext && (i[31:26] == 6'h00 && i[5:3] == 3'h6 || i[31:26] == 6'h01 && i[20:19] == 2'h1)) return t ? 3'h3 : 3'h4;
    return 3'h0;
  endfunction
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ready_wait();
    for (int k = 0; k < 40 && !rdy; k++) @(negedge clk);
    chk("ready", rdy, 1'b1);
  endtask
  task automatic issue(logic [31:0] i, logic [63:0] a, logic [63:0] b);
    logic [2:0] e;
    e = want(i, a, b, 1);
    req = {i, rnd(), rnd(), a, b, 1'b0};
    vld = 1;
    @(negedge clk);
    chk("answer", {ret, exc ? eo.cause : 2'h0}, e);
    chk("answer_base", {b_ret, b_exc ? b_eo.cause : 2'h0}, want(i, a, b, 0));
    // valid stays up for back-to-back work; an exception refuses work, so it drops
    if (e[1:0] != 2'h0) begin
      vld = 0;
      chk("epc", eo.epc, req.pc);
      chk("held", {flush, rdy}, 2'h2);
      ready_wait();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] r, i;
    logic [63:0] a, b;
    rstn = 0;
    vld = 0;
    mst = 0;
    aw = 0;
    req = '0;
    repeat (16) @(negedge clk);
    rstn = 1;
    chk("idle", {exc, ret, flush, rdy, hold}, 5'h02);
    // corner operands: extremes near the signed and unsigned wrap points, equal pairs
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      a = {rnd(), rnd()};
      if (r[3]) a = {r[4], 63'h0} - r[6:5];
      b = r[7] ? a : {rnd(), rnd()};
      i = r[8] ? {6'h01, 5'(rnd()), 2'h1, r[2:0], 16'(rnd())} : {6'h00, 20'(rnd()), 3'h6, r[2:0]};
      if (r[8] && r[7]) a = {{48{i[15]}}, i[15:0]};
      if (r[9]) i = {6'h00, 20'(rnd()), r[10] ? 6'h0C : 6'h0D};
      aw = r[14:11];
      issue(i, a, b);
    end
    vld = 0;
    $display("test random traps done");
    mst = 1;
    @(negedge clk);
    mst = 0;
    issue({26'h0, 6'h0F}, 64'h0, 64'h0);
    chk("hold", hold, 1'b1);
    issue({26'h0, 6'h31}, 64'h1, 64'h2);
    req = {32'h8C000000, 192'h0, 1'b1};
    vld = 1;
    for (int k = 0; k < 20; k++) begin
      #1;
      if (pend) chk("stall", rdy, 1'b0);
      if (rdy) break;
      @(negedge clk);
    end
    chk("taken", {rdy, pend, hold}, 3'h4);
    @(negedge clk);
    vld = 0;
    $display("test barrier done");
    conclude();
  end
endmodule
